// File: verilog/sssl_start_stop.v
// Run-command logic: two/three-wire start/stop and command source selection
`timescale 1ns/10ps
`default_nettype none
`include "sssl_defines.vh"
// What this block does
// [R1] Two-wire: run while start level held
// [R2] Three-wire: latch on start, drop on stop low
// [R3] Start edge picks three-wire if stop high
// [R4] Input two energized selects remote source
// [R5] Keypad source uses keypad, terminal uses input
// [R6] Installer sets hand/off/auto source settings
// [R7] Wiring holds stop high hand, low auto
// [R8] Requests from unselected source are ignored
module sssl_start_stop (
  input wire clock, // System clock, 20 MHz
  input wire resetn, // Asynchronous reset, active low
  input wire start_pin, // Start digital input (pin)
  input wire stop_pin, // Stop digital input (pin), high = not stopping
  input wire source_select_input, // Digital input 2 (pin)
  input wire stop_pin_assigned, // Stop pin carries the stop function
  input wire [`SSSL_DI2_FUNC_W-1:0] input_two_function_setting, // Input 2 function
  input wire local_source_setting, // Local source: 0 terminal, 1 keypad
  input wire remote_source_setting, // Remote source: 0 terminal, 1 keypad
  input wire keypad_start, // Keypad start request, one-cycle pulse
  input wire keypad_stop, // Keypad stop request, one-cycle pulse
  output reg run_out, // Run command to the starter
  output reg three_wire_out, // High while three-wire behaviour is in use
  output reg remote_active_out, // High while the remote source is selected
  output reg keypad_active_out // High while the keypad is the active source
);
  // One-hot state codes
  localparam [`SSSL_ST_W-1:0] ST_IDLE = `SSSL_ST_IDLE;
  localparam [`SSSL_ST_W-1:0] ST_RUN2 = `SSSL_ST_RUN2;
  localparam [`SSSL_ST_W-1:0] ST_RUN3 = `SSSL_ST_RUN3;

  wire [`SSSL_SYNC_W-1:0] pins_raw;
  wire [`SSSL_SYNC_W-1:0] pins_sync;
  wire start_s;
  wire stop_s;
  wire di2_s;
  wire start_rise;
  wire term_active;

  reg start_prev_q;
  reg [`SSSL_ST_W-1:0] state_q;
  reg [`SSSL_ST_W-1:0] state_d;
  reg di2_is_locrem;
  reg di2_is_stop;
  reg remote_sel;
  reg src_keypad;
  reg stop_func_present;
  reg stop_high;
  reg term_start_req;
  reg term_level_lost;
  reg term_stop_req;
  reg kp_start_req;
  reg kp_stop_req;

  // Pin inputs pass two flops before any logic reads them
  assign pins_raw[`SSSL_SYNC_START] = start_pin;
  assign pins_raw[`SSSL_SYNC_STOP] = stop_pin;
  assign pins_raw[`SSSL_SYNC_DI2] = source_select_input;

  sssl_sync #(
    .WIDTH(`SSSL_SYNC_W)
  ) u_sync (
    .clock(clock),
    .resetn(resetn),
    .din(pins_raw),
    .dout(pins_sync)
  );

  assign start_s = pins_sync[`SSSL_SYNC_START];
  assign stop_s = pins_sync[`SSSL_SYNC_STOP];
  assign di2_s = pins_sync[`SSSL_SYNC_DI2];

  // A start edge is judged on the synchronised level only
  assign start_rise = start_s & ~start_prev_q; // [R3]

  always @* begin
    di2_is_locrem = (input_two_function_setting == `SSSL_DI2_FUNC_LOCREM);
    di2_is_stop = (input_two_function_setting == `SSSL_DI2_FUNC_STOP);
  end

  // Energised input two selects the remote source
  always @* begin
    remote_sel = di2_is_locrem & di2_s; // [R4]
    if (remote_sel) begin
      src_keypad = remote_source_setting; // [R4]
    end else begin
      src_keypad = local_source_setting; // [R4]
    end
  end

  // Every input that carries the stop function must be high; any one low stops
  always @* begin
    stop_func_present = stop_pin_assigned | di2_is_stop;
    stop_high = stop_func_present;
    if (stop_pin_assigned && !stop_s) begin
      stop_high = 1'b0; // [R2]
    end
    if (di2_is_stop && !di2_s) begin
      stop_high = 1'b0; // [R2]
    end
  end

  assign term_active = (src_keypad == `SSSL_SRC_TERMINAL); // [R5]

  // Terminal requests, ignored while the keypad is the active source
  always @* begin
    term_start_req = 1'b0;
    term_level_lost = 1'b0;
    term_stop_req = 1'b0;
    if (term_active) begin // [R8]
      term_start_req = start_rise; // [R5]
      term_level_lost = ~start_s; // [R1]
      term_stop_req = stop_func_present & ~stop_high; // [R2]
    end
  end

  // Keypad requests, ignored while the terminal is the active source
  always @* begin
    kp_start_req = 1'b0;
    kp_stop_req = 1'b0;
    if (!term_active) begin // [R8]
      kp_start_req = keypad_start & ~keypad_stop; // [R5]
      kp_stop_req = keypad_stop; // [R5]
    end
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (kp_start_req) begin
          // Keypad starts are always latched
          state_d = ST_RUN3; // [R5]
        end else if (term_start_req) begin
          if (stop_high) begin
            state_d = ST_RUN3; // [R3]
          end else begin
            state_d = ST_RUN2; // [R3]
          end
        end
      end
      ST_RUN2: begin
        if (!term_active) begin
          // A maintained level cannot come from the keypad
          state_d = ST_IDLE; // [R8]
        end else if (term_level_lost) begin
          state_d = ST_IDLE; // [R1]
        end
      end
      ST_RUN3: begin
        if (kp_stop_req) begin
          state_d = ST_IDLE; // [R5]
        end else if (term_stop_req) begin
          state_d = ST_IDLE; // [R2]
        end else if (term_active && !stop_func_present) begin
          // No stop input left: fall back to following the start level
          if (start_s) begin
            state_d = ST_RUN2;
          end else begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      start_prev_q <= 1'b0;
    end else begin
      start_prev_q <= start_s;
    end
  end

  // Run command
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      run_out <= 1'b0;
    end else begin
      run_out <= (state_d != ST_IDLE); // [R1] [R2]
    end
  end

  // Latched behaviour in use
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      three_wire_out <= 1'b0;
    end else begin
      three_wire_out <= (state_d == ST_RUN3); // [R3]
    end
  end

  // Remote source in use
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      remote_active_out <= 1'b0;
    end else begin
      remote_active_out <= remote_sel; // [R4]
    end
  end

  // Keypad is the active source
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      keypad_active_out <= 1'b0;
    end else begin
      keypad_active_out <= src_keypad; // [R5]
    end
  end

endmodule // sssl_start_stop
`default_nettype wire

// File: inc/sssl_defines.vh
// Constants shared by the start/stop and command source logic
`ifndef SSSL_DEFINES_VH
`define SSSL_DEFINES_VH
`define SSSL_SRC_TERMINAL 1'b0
`define SSSL_SRC_KEYPAD 1'b1
`define SSSL_DI2_FUNC_W 2
`define SSSL_DI2_FUNC_NONE 2'h0
`define SSSL_DI2_FUNC_LOCREM 2'h1
`define SSSL_DI2_FUNC_STOP 2'h2
`define SSSL_SYNC_W 3
`define SSSL_SYNC_START 0
`define SSSL_SYNC_STOP 1
`define SSSL_SYNC_DI2 2
`define SSSL_ST_W 3
`define SSSL_ST_IDLE 3'h1
`define SSSL_ST_RUN2 3'h2
`define SSSL_ST_RUN3 3'h4
`endif

// File: verilog/sssl_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module sssl_sync #(
  parameter WIDTH = 4
) (
  input wire clock, // System clock
  input wire resetn, // Asynchronous reset, active low
  input wire [WIDTH-1:0] din, // Asynchronous inputs
  output wire [WIDTH-1:0] dout // Synchronised outputs
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      // Each bit owns its flops, so no vector has several driving blocks
      reg meta_q;
      reg sync_q;
      always @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= din[i];
          sync_q <= meta_q;
        end
      end
      assign dout[i] = sync_q;
    end
  endgenerate
endmodule // sssl_sync
`default_nettype wire

// File: verif/sssl_props.sv
// Port assertions for the run-command logic
`timescale 1ns/10ps
`default_nettype none
module sssl_props (
  input wire logic clock, resetn, start_pin, stop_pin, source_select_input, stop_pin_assigned,
  input wire logic [1:0] input_two_function_setting,
  input wire logic local_source_setting, remote_source_setting, keypad_start, keypad_stop,
  input wire logic run_out, three_wire_out, remote_active_out, keypad_active_out);
  logic [2:0] up_q;
  always @(posedge clock or negedge resetn)
    if (!resetn) up_q <= 3'h0;
    else if (!up_q[2]) up_q <= up_q + 3'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  a_remote_sel: assert property (up_q[2] && input_two_function_setting == 2'h1 &&
    $stable(source_select_input)[*4] |-> remote_active_out == source_select_input)
    else $error("remote select wrong");
  a_src_pick: assert property (up_q[2] &&
    $stable({remote_active_out, local_source_setting, remote_source_setting})[*2] |->
    keypad_active_out == (remote_active_out ? remote_source_setting : local_source_setting))
    else $error("source pick wrong");
  a_rise_cause: assert property ($rose(run_out) |->
    $past(keypad_start) && keypad_active_out ||
    $past(start_pin, 3) && !keypad_active_out) else $error("run without request");
  a_wire_mode: assert property ($rose(run_out) && !keypad_active_out &&
    $past(input_two_function_setting) != 2'h2 |->
    three_wire_out == ($past(stop_pin, 3) && $past(stop_pin_assigned))) else $error("bad mode");
  // Two sync flops and the output register lie between a pin and the run command
  sequence s_gone_after_sync;
    ##3 !run_out;
  endsequence
  a_two_drop: assert property ($fell(start_pin) && run_out && !three_wire_out &&
    !keypad_active_out |-> s_gone_after_sync) else $error("two-wire run held");
  a_three_drop: assert property ($fell(stop_pin) && stop_pin_assigned && three_wire_out &&
    !keypad_active_out |-> s_gone_after_sync) else $error("latched run held");
  a_keypad_start: assert property (keypad_start && !keypad_stop && !run_out |=>
    run_out && three_wire_out || !keypad_active_out) else $error("keypad start lost");
  a_keypad_stop: assert property (keypad_stop && run_out |=>
    !run_out || !keypad_active_out) else $error("keypad stop lost");
endmodule // sssl_props
bind sssl_start_stop sssl_props chk_u (.*);
`default_nettype wire

// File: verif/sssl_operator.sv
// Operator station: selector switch, pushbuttons and run contact
`timescale 1ns/10ps
`default_nettype none
module sssl_operator (
  input wire logic [1:0] sw, // 0 off, 1 hand, 2 auto, 3 pushbuttons
  input wire logic plc_run, pb_start, pb_stop,
  output logic start_pin, stop_pin, source_select_input);
  assign source_select_input = sw == 2'h1;
  assign stop_pin = sw == 2'h1 || sw == 2'h3 && !pb_stop;
  assign start_pin = sw == 2'h2 && plc_run || sw == 2'h3 && pb_start;
endmodule // sssl_operator
`default_nettype wire

// File: verif/tb_top.sv
// Table-driven bench for the run-command logic
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clock = 0, resetn = 0, plc_run = 0, pb_start = 0, pb_stop = 0, keypad_start = 0;
  logic keypad_stop = 0, start_pin, stop_pin, source_select_input, run_out, three_wire_out;
  logic remote_active_out, keypad_active_out, stop_pin_assigned = 1;
  logic local_source_setting = 0, remote_source_setting = 1;
  logic [1:0] sw = 0, input_two_function_setting = 2'h1;
  logic [31:0] lf = 32'hAEF830C1;
  logic [10:0] steps [11] = '{11'h000, 11'h508, 11'h400, 11'h68C, 11'h60C, 11'h640,
    11'h203, 11'h22F, 11'h213, 11'h22F, 11'h400};
  int n_errors = 0, samples_checked = 0;
  int exp_q[$];
  int m_run = 0, m_three = 0, m_prev_start = 0;
  logic [3:0] outs;
  always #25 clock = ~clock;
  sssl_operator op_u (
    .sw(sw),
    .plc_run(plc_run),
    .pb_start(pb_start),
    .pb_stop(pb_stop),
    .start_pin(start_pin),
    .stop_pin(stop_pin),
    .source_select_input(source_select_input)
  );
  sssl_start_stop dut_u (
    .clock(clock),
    .resetn(resetn),
    .start_pin(start_pin),
    .stop_pin(stop_pin),
    .source_select_input(source_select_input),
    .stop_pin_assigned(stop_pin_assigned),
    .input_two_function_setting(input_two_function_setting),
    .local_source_setting(local_source_setting),
    .remote_source_setting(remote_source_setting),
    .keypad_start(keypad_start),
    .keypad_stop(keypad_stop),
    .run_out(run_out),
    .three_wire_out(three_wire_out),
    .remote_active_out(remote_active_out),
    .keypad_active_out(keypad_active_out)
  );
  assign outs = {run_out, three_wire_out, remote_active_out, keypad_active_out};
  function automatic logic [31:0] nx(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic print_verdict;
    if (n_errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string name, input logic [3:0] seen, input logic [3:0] expected);
    samples_checked++;
    if (seen !== expected) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, expected, seen);
    end
  endtask
  // Step-level model of the run state, fed from the settled pin levels
  task automatic model_step(input logic ks, input logic kstop);
    int rem, kp, stop_ok;
    rem = input_two_function_setting == 2'h1 && source_select_input;
    kp = rem ? remote_source_setting : local_source_setting;
    stop_ok = stop_pin_assigned && stop_pin;
    if (kp) begin
      if (kstop || !m_three) m_run = 0;
      if (ks && !kstop && !m_run) begin
        m_run = 1;
        m_three = 1;
      end
    end else begin
      if (!m_three && !start_pin || m_three && !stop_ok) m_run = 0;
      if (start_pin && !m_prev_start && !m_run) begin
        m_run = 1;
        m_three = stop_ok;
      end
    end
    if (!m_run) m_three = 0;
    m_prev_start = start_pin;
    exp_q.push_back(m_run * 8 + m_three * 4 + rem * 2 + kp);
  endtask
  initial begin
    repeat (12) @(posedge clock);
    resetn <= 1;
    foreach (steps[i]) begin
      @(posedge clock);
      {sw, plc_run, pb_start, pb_stop, keypad_start, keypad_stop} <= steps[i][10:4];
      for (int k = 0; k < 8; k++) begin
        @(posedge clock);
        lf = nx(lf);
        keypad_start <= k > 3 && steps[i][10:9] != 2'h1 && lf[0];
        keypad_stop <= 1'b0;
      end
      #1 model_step(steps[i][5], steps[i][4]);
      check("outputs vs table", outs, steps[i][3:0]);
      check("outputs vs model", outs, 4'(exp_q.pop_front()));
    end
    print_verdict;
  end
  initial begin
    #20us;
    n_errors++;
    print_verdict;
  end
endmodule // tb_top
`default_nettype wire
